// [inc/serial_port_regs.vh]
`ifndef SERIAL_PORT_REGS_VH
`define SERIAL_PORT_REGS_VH
// Register indices; byte address is four times the index
`define PWR_RATE_IDX    8'h87
`define SER_CTRL_IDX    8'h98
`define SER_BUF_IDX     8'h99
`define INT_EN_IDX      8'hA8
`define NODE_ADDR_IDX   8'hA9
`define PRIO_HIGH_IDX   8'hB7
`define PRIO_LOW_IDX    8'hB8
`define NODE_MASK_IDX   8'hB9
`define RATE_DIV_IDX    8'hC0
// Reset values
`define PWR_RATE_RST    8'h10
`define BYTE_RST        8'h00
`define RATE_DIV_RST    8'h00
// Serial control fields
`define SC_BIT7         7
`define SC_MODE1        6
`define SC_MPE          5
`define SC_REN          4
`define SC_TX9          3
`define SC_RX9          2
`define SC_TXDONE       1
`define SC_RXDONE       0
// Power and rate control fields
`define PR_DOUBLE       7
`define PR_BIT7SEL      6
`define PR_UNUSED       5
// Interrupt enable and priority fields
`define IEN_ALL         7
`define IEN_SER         4
`define PRI_SER         4
// Mode codes, {mode_bit_zero, mode_bit_one}
`define MODE_SHIFT      2'b00
`define MODE_UART8      2'b01
`define MODE_UART9F     2'b10
`define MODE_UART9V     2'b11
// Bit timing in system clocks
`define SHIFT_DIV       16'h000C
`define SHIFT_HALF      4'h6
`define SHIFT_LAST      4'hB
`define FIX_DIV_SLOW    16'h0040
`define FIX_DIV_FAST    16'h0020
`define VAR_MUL_SLOW    16'h0020
`define VAR_MUL_FAST    16'h0010
`endif

// [rtl/frame_sender.v]
`timescale 1ns/100ps
module frame_sender (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        start,
  input  wire [7:0]  data,
  input  wire        ninth,
  input  wire        use_ninth,
  input  wire [15:0] period,
  output reg         line_r,
  output reg         busy_r,
  output reg         done_r
);
  reg [10:0] sh_r;
  reg [3:0]  left_r;
  reg [15:0] cnt_r;

  // Frame is start 0, eight data LSB first, optional ninth, stop 1
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_r <= 1'b1;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      sh_r   <= 11'h7FF;
      left_r <= 4'h0;
      cnt_r  <= 16'h0000;
    end else if (ce) begin
      done_r <= 1'b0;
      if (!busy_r) begin
        if (start) begin
          sh_r   <= {1'b1, (ninth | ~use_ninth), data, 1'b0}; // RULE_12 RULE_20 RULE_22
          left_r <= use_ninth ? 4'hB : 4'hA;                 // RULE_22
          cnt_r  <= 16'h0000;
          busy_r <= 1'b1;
        end
      end else if (cnt_r == 16'h0000) begin
        if (left_r == 4'h0) begin
          busy_r <= 1'b0;
          done_r <= 1'b1;
          line_r <= 1'b1;
        end else begin
          line_r <= sh_r[0];
          sh_r   <= {1'b1, sh_r[10:1]};
          left_r <= left_r - 4'h1;
          cnt_r  <= period - 16'h0001;
        end
      end else begin
        cnt_r <= cnt_r - 16'h0001;
      end
    end
  end
endmodule // frame_sender

// [rtl/frame_receiver.v]
`timescale 1ns/100ps
module frame_receiver (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        enable,
  input  wire        line,
  input  wire        use_ninth,
  input  wire [15:0] period,
  output reg         done_r,
  output reg  [7:0]  data_r,
  output reg         ninth_r,
  output reg         stop_ok_r
);
  localparam ST_IDLE  = 2'b00;
  localparam ST_START = 2'b01;
  localparam ST_BITS  = 2'b10;

  reg [1:0]  st_r;
  reg [3:0]  bit_r;
  reg [15:0] cnt_r;
  wire [3:0] stop_pos = use_ninth ? 4'h9 : 4'h8;

  // Samples each bit mid-cell; a glitch shorter than half a bit is dropped
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r      <= ST_IDLE;
      bit_r     <= 4'h0;
      cnt_r     <= 16'h0000;
      done_r    <= 1'b0;
      data_r    <= 8'h00;
      ninth_r   <= 1'b0;
      stop_ok_r <= 1'b0;
    end else if (ce) begin
      done_r <= 1'b0;
      if (!enable) begin
        st_r <= ST_IDLE;                          // RULE_11
      end else begin
        case (st_r)
          ST_IDLE: begin
            if (!line) begin
              st_r  <= ST_START;
              cnt_r <= {1'b0, period[15:1]};
            end
          end
          ST_START: begin
            if (cnt_r != 16'h0000) begin
              cnt_r <= cnt_r - 16'h0001;
            end else if (!line) begin
              st_r  <= ST_BITS;
              bit_r <= 4'h0;
              cnt_r <= period - 16'h0001;
            end else begin
              st_r <= ST_IDLE;
            end
          end
          ST_BITS: begin
            if (cnt_r != 16'h0000) begin
              cnt_r <= cnt_r - 16'h0001;
            end else begin
              cnt_r <= period - 16'h0001;
              bit_r <= bit_r + 4'h1;
              if (bit_r < 4'h8) begin
                data_r[bit_r[2:0]] <= line;       // RULE_20 RULE_22
              end else if (bit_r != stop_pos) begin
                ninth_r <= line;                  // RULE_13
              end else begin
                if (!use_ninth) begin
                  ninth_r <= line;                // RULE_20
                end
                stop_ok_r <= line;
                done_r    <= 1'b1;
                st_r      <= ST_IDLE;
              end
            end
          end
          default: st_r <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // frame_receiver

// [rtl/enhanced_serial_port.v]
// Notes on behaviour
// RULE_01: Transmit and receive run at once, independently.
// RULE_02: New character assembles while old one waits.
// RULE_03: Unread held character means one is lost.
// RULE_04: Buffer address: write transmits, read returns received.
// RULE_05: Mode field picks shift register or UARTs.
// RULE_06: Mode 2 rate clock/64, doubled gives /32.
// RULE_07: Doubling clear keeps normal rates.
// RULE_08: Modes 2,3 multiprocessor: ninth one and address.
// RULE_09: Mode 1 multiprocessor: good stop and address.
// RULE_10: Software keeps multiprocessor enable clear in mode 0.
// RULE_11: Reception only while receive enable set.
// RULE_12: Modes 2,3 send stored ninth bit.
// RULE_13: Modes 2,3 store received ninth bit.
// RULE_14: Transmit and receive flags at bits 1, 0.
// RULE_15: Bad stop bit sets framing error always.
// RULE_16: Framing error cleared only by software.
// RULE_17: Select bit steers bit 7: error or mode.
// RULE_18: Broadcast is address OR mask; zero disables.
// RULE_19: Mask gates node address into given address.
// RULE_20: Mode 1 frame: start, eight data, stop.
// RULE_21: Flags stay set; enabled flags request interrupt.
// RULE_22: Modes 2,3 frame adds ninth bit.
`timescale 1ns/100ps
`include "serial_port_regs.vh"
module enhanced_serial_port (
  input  wire        hclk,
  input  wire        hresetn,
  input  wire        ce,
  input  wire        hsel,
  input  wire [31:0] haddr,
  input  wire [1:0]  htrans,
  input  wire        hwrite,
  input  wire [2:0]  hsize,
  input  wire [31:0] hwdata,
  input  wire        hready,
  output reg  [31:0] hrdata,
  output reg         hreadyout,
  output reg         hresp,
  output reg         txd_r,
  input  wire        rxd_i,
  output reg         rxd_o_r,
  output reg         rxd_oe_r,
  output reg         serial_irq_r,
  output reg  [1:0]  serial_priority_r
);
  localparam M0_IDLE = 2'b00;
  localparam M0_TX   = 2'b01;
  localparam M0_RX   = 2'b10;

  // Register state
  reg        mode_bit_zero_r;
  reg        mode_bit_one_r;
  reg        multiprocessor_enable_r;
  reg        receive_enable_r;
  reg        transmit_ninth_bit_r;
  reg        receive_ninth_bit_r;
  reg        transmit_complete_flag_r;
  reg        receive_complete_flag_r;
  reg        framing_error_flag_r;
  reg  [7:0] pwr_rate_r;
  reg  [7:0] rx_hold_r;
  reg  [7:0] tx_hold_r;
  reg  [7:0] int_en_r;
  reg  [7:0] node_addr_r;
  reg  [7:0] node_mask_r;
  reg  [7:0] prio_high_r;
  reg  [7:0] prio_low_r;
  reg  [7:0] rate_div_r;

  // Bus slave state
  reg        dph_r;
  reg        dwr_r;
  reg  [7:0] didx_r;
  reg  [7:0] rd_mux;

  // Line side state
  reg        rxd_meta_r;
  reg        rxd_s_r;
  reg  [1:0] m0_st_r;
  reg  [3:0] m0_cnt_r;
  reg  [3:0] m0_bit_r;
  reg  [7:0] m0_sh_r;

  wire       rate_double = pwr_rate_r[`PR_DOUBLE];
  wire       bit7_function_select = pwr_rate_r[`PR_BIT7SEL];
  wire [1:0] mode = {mode_bit_zero_r, mode_bit_one_r};  // RULE_05
  wire       nine = mode[1];

  // Bit period in system clocks for the selected mode
  function [15:0] bit_cycles;
    input [1:0] md;
    input       dbl;
    input [7:0] dv;
    reg   [15:0] step;
    begin
      step = {8'h00, dv} + 16'h0001;
      case (md)
        `MODE_SHIFT:  bit_cycles = `SHIFT_DIV;
        `MODE_UART9F: bit_cycles = dbl ? `FIX_DIV_FAST : `FIX_DIV_SLOW;  // RULE_06 RULE_07
        default: begin
          bit_cycles = step * (dbl ? `VAR_MUL_FAST : `VAR_MUL_SLOW);     // RULE_06 RULE_07
        end
      endcase
    end
  endfunction

  // Address filter: given match under mask, or broadcast match
  function addr_hit;
    input [7:0] rx;
    input [7:0] adr;
    input [7:0] msk;
    reg   [7:0] bcast;
    begin
      bcast = adr | msk;                                  // RULE_18
      addr_hit = (bcast == 8'h00) |                       // RULE_18
                 (((rx ^ adr) & msk) == 8'h00) |          // RULE_19
                 (((rx ^ bcast) & bcast) == 8'h00);       // RULE_18
    end
  endfunction

  wire [15:0] period = bit_cycles(mode, rate_double, rate_div_r);

  // Access decode; every transfer takes one wait state
  wire a_take = hsel & htrans[1] & hready & hreadyout;
  wire wr_en  = dph_r & dwr_r;
  wire buf_wr = wr_en & (didx_r == `SER_BUF_IDX);        // RULE_04

  // The asynchronous sender sees the start pulse from a buffer write
  wire tx_busy;
  wire tx_line;
  wire tx_done;
  wire rx_done;
  wire [7:0] rx_data;
  wire rx_ninth;
  wire rx_stop_ok;
  wire is_async = (mode != `MODE_SHIFT);

  // Separate send and receive engines share only the period and the ninth bit select
  frame_sender u_send (                                  // RULE_01
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .start     (buf_wr & is_async),
    .data      (hwdata[7:0]),
    .ninth     (transmit_ninth_bit_r),
    .use_ninth (nine),
    .period    (period),
    .line_r    (tx_line),
    .busy_r    (tx_busy),
    .done_r    (tx_done)
  );

  frame_receiver u_recv (                                // RULE_01 RULE_02
    .hclk      (hclk),
    .hresetn   (hresetn),
    .ce        (ce),
    .enable    (receive_enable_r & is_async),            // RULE_11
    .line      (rxd_s_r),
    .use_ninth (nine),
    .period    (period),
    .done_r    (rx_done),
    .data_r    (rx_data),
    .ninth_r   (rx_ninth),
    .stop_ok_r (rx_stop_ok)
  );

  // Held character is never overwritten; the newer one is dropped
  wire rx_hit  = addr_hit(rx_data, node_addr_r, node_mask_r);
  wire rx_take = rx_done & ~receive_complete_flag_r &    // RULE_03
                 (~multiprocessor_enable_r | (rx_ninth & rx_hit));  // RULE_08 RULE_09
  wire m0_end  = (m0_cnt_r == `SHIFT_LAST) & (m0_bit_r == 4'h7);
  wire m0_tx_done = (m0_st_r == M0_TX) & m0_end;
  wire m0_rx_done = (m0_st_r == M0_RX) & m0_end;

  // Pin input synchroniser
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rxd_meta_r <= 1'b1;
      rxd_s_r    <= 1'b1;
    end else if (ce) begin
      rxd_meta_r <= rxd_i;
      rxd_s_r    <= rxd_meta_r;
    end
  end

  // Read mux; bit 7 of the control register follows the select bit
  always @* begin
    case (didx_r)
      `SER_CTRL_IDX: rd_mux = {(bit7_function_select ? framing_error_flag_r
                                                     : mode_bit_zero_r),     // RULE_17
                               mode_bit_one_r, multiprocessor_enable_r,
                               receive_enable_r, transmit_ninth_bit_r,
                               receive_ninth_bit_r,
                               transmit_complete_flag_r,                     // RULE_14
                               receive_complete_flag_r};                     // RULE_14
      `SER_BUF_IDX:   rd_mux = rx_hold_r;                                    // RULE_04
      `PWR_RATE_IDX:  rd_mux = pwr_rate_r & ~(8'h01 << `PR_UNUSED);
      `INT_EN_IDX:    rd_mux = int_en_r;
      `NODE_ADDR_IDX: rd_mux = node_addr_r;
      `NODE_MASK_IDX: rd_mux = node_mask_r;
      `PRIO_HIGH_IDX: rd_mux = prio_high_r;
      `PRIO_LOW_IDX:  rd_mux = prio_low_r;
      `RATE_DIV_IDX:  rd_mux = rate_div_r;
      default:        rd_mux = 8'h00;
    endcase
  end

  // Bus slave: address phase, one wait cycle, then the answer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_r     <= 1'b0;
      dwr_r     <= 1'b0;
      didx_r    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else if (ce) begin
      hresp <= 1'b0;
      if (dph_r) begin
        dph_r     <= 1'b0;
        hreadyout <= 1'b1;
        hrdata    <= dwr_r ? 32'h0000_0000 : {24'h000000, rd_mux};
      end else if (a_take) begin
        dph_r     <= 1'b1;
        dwr_r     <= hwrite;
        didx_r    <= haddr[9:2];
        hreadyout <= 1'b0;
      end
    end
  end

  // Registers; hardware sets come after software writes so sets win
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_bit_zero_r          <= 1'b0;
      mode_bit_one_r           <= 1'b0;
      multiprocessor_enable_r  <= 1'b0;
      receive_enable_r         <= 1'b0;
      transmit_ninth_bit_r     <= 1'b0;
      receive_ninth_bit_r      <= 1'b0;
      transmit_complete_flag_r <= 1'b0;
      receive_complete_flag_r  <= 1'b0;
      framing_error_flag_r     <= 1'b0;
      pwr_rate_r               <= `PWR_RATE_RST;
      rx_hold_r                <= `BYTE_RST;
      tx_hold_r                <= `BYTE_RST;
      int_en_r                 <= `BYTE_RST;
      node_addr_r              <= `BYTE_RST;
      node_mask_r              <= `BYTE_RST;
      prio_high_r              <= `BYTE_RST;
      prio_low_r               <= `BYTE_RST;
      rate_div_r               <= `RATE_DIV_RST;
    end else if (ce) begin
      if (wr_en) begin
        case (didx_r)
          `SER_CTRL_IDX: begin
            if (bit7_function_select) begin
              framing_error_flag_r <= hwdata[`SC_BIT7];  // RULE_16 RULE_17
            end else begin
              mode_bit_zero_r <= hwdata[`SC_BIT7];       // RULE_17
            end
            mode_bit_one_r           <= hwdata[`SC_MODE1];
            multiprocessor_enable_r  <= hwdata[`SC_MPE];
            receive_enable_r         <= hwdata[`SC_REN];
            transmit_ninth_bit_r     <= hwdata[`SC_TX9];
            receive_ninth_bit_r      <= hwdata[`SC_RX9];
            transmit_complete_flag_r <= hwdata[`SC_TXDONE];
            receive_complete_flag_r  <= hwdata[`SC_RXDONE];
          end
          `SER_BUF_IDX:   tx_hold_r   <= hwdata[7:0];    // RULE_04
          `PWR_RATE_IDX:  pwr_rate_r  <= hwdata[7:0];
          `INT_EN_IDX:    int_en_r    <= hwdata[7:0];
          `NODE_ADDR_IDX: node_addr_r <= hwdata[7:0];
          `NODE_MASK_IDX: node_mask_r <= hwdata[7:0];
          `PRIO_HIGH_IDX: prio_high_r <= hwdata[7:0];
          `PRIO_LOW_IDX:  prio_low_r  <= hwdata[7:0];
          `RATE_DIV_IDX:  rate_div_r  <= hwdata[7:0];
          default: begin
          end
        endcase
      end
      // Flags stay set until software writes them clear
      if (tx_done | m0_tx_done) begin
        transmit_complete_flag_r <= 1'b1;                // RULE_14 RULE_21
      end
      if (rx_done & is_async & ~rx_stop_ok) begin
        framing_error_flag_r <= 1'b1;                    // RULE_15 RULE_16
      end
      if (rx_take & is_async) begin
        rx_hold_r               <= rx_data;              // RULE_02
        receive_ninth_bit_r     <= rx_ninth;             // RULE_13 RULE_20
        receive_complete_flag_r <= 1'b1;                 // RULE_14 RULE_21
      end
      if (m0_rx_done) begin
        rx_hold_r               <= m0_sh_r;      // All eight samples already in
        receive_complete_flag_r <= 1'b1;                 // RULE_21
      end
    end
  end

  // Shift register mode: clock on txd, data both ways on rxd
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m0_st_r  <= M0_IDLE;
      m0_cnt_r <= 4'h0;
      m0_bit_r <= 4'h0;
      m0_sh_r  <= 8'h00;
    end else if (ce) begin
      case (m0_st_r)
        M0_IDLE: begin
          m0_cnt_r <= 4'h0;
          m0_bit_r <= 4'h0;
          if (!is_async && buf_wr) begin
            m0_st_r <= M0_TX;                            // RULE_05
            m0_sh_r <= hwdata[7:0];
          end else if (!is_async && receive_enable_r &&
                       !receive_complete_flag_r) begin
            m0_st_r <= M0_RX;                            // RULE_11
          end
        end
        M0_TX, M0_RX: begin
          if (m0_st_r == M0_RX && m0_cnt_r == `SHIFT_HALF) begin
            m0_sh_r <= {rxd_s_r, m0_sh_r[7:1]};          // Sample at rising edge
          end
          if (m0_cnt_r == `SHIFT_LAST) begin
            m0_cnt_r <= 4'h0;
            m0_bit_r <= m0_bit_r + 4'h1;
            if (m0_st_r == M0_TX) begin
              m0_sh_r <= {1'b0, m0_sh_r[7:1]};
            end
            if (m0_end) begin
              m0_st_r <= M0_IDLE;
            end
          end else begin
            m0_cnt_r <= m0_cnt_r + 4'h1;
          end
          if (is_async) begin
            m0_st_r <= M0_IDLE;                          // Mode change aborts
          end
        end
        default: m0_st_r <= M0_IDLE;
      endcase
    end
  end

  // Pins and interrupt request, all registered
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txd_r             <= 1'b1;
      rxd_o_r           <= 1'b1;
      rxd_oe_r          <= 1'b0;
      serial_irq_r      <= 1'b0;
      serial_priority_r <= 2'b00;
    end else if (ce) begin
      if (is_async) begin
        txd_r <= tx_line;                                // RULE_01
      end else begin
        txd_r <= (m0_st_r == M0_IDLE) | (m0_cnt_r >= `SHIFT_HALF);
      end
      rxd_oe_r <= (m0_st_r == M0_TX);
      rxd_o_r  <= (m0_st_r == M0_TX) ? m0_sh_r[0] : 1'b1;
      serial_irq_r <= (transmit_complete_flag_r | receive_complete_flag_r) &
                      int_en_r[`IEN_SER] & int_en_r[`IEN_ALL];  // RULE_21
      serial_priority_r <= {prio_high_r[`PRI_SER], prio_low_r[`PRI_SER]};
    end
  end
endmodule // enhanced_serial_port

// [tb/serial_port_props.sv]
`timescale 1ns/100ps
module serial_port_props (
  input wire        hclk,
  input wire        hresetn,
  input wire        ce,
  input wire        hsel,
  input wire [1:0]  htrans,
  input wire        hready,
  input wire [31:0] hrdata,
  input wire        hreadyout,
  input wire        hresp,
  input wire        txd_r,
  input wire        serial_irq_r,
  input wire [1:0]  serial_priority_r
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Address phase accepted by the slave
  wire taken = ce && hsel && htrans[1] && hready && hreadyout;
  property p_wait;
    taken |=> !hreadyout ##1 hreadyout;
  endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_idle;
    ce && hreadyout && !taken |=> hreadyout;
  endproperty
  a_idle: assert property (p_idle) else $error("stall with no transfer");
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  // Read data may only move as a transfer completes
  property p_rd_hold;
    !hreadyout |-> $stable(hrdata);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data moved early");
  property p_rd_cause;
    !$stable(hrdata) |-> !$past(hreadyout);
  endproperty
  a_rd_cause: assert property (p_rd_cause) else $error("read data moved alone");
  // No bit on the line is shorter than six cycles, even doubled
  property p_bit_min;
    $fell(txd_r) |=> $stable(txd_r) [*5];
  endproperty
  a_bit_min: assert property (p_bit_min) else $error("bit too short");
  // Flags drop only through a register write one or two cycles back
  property p_irq_fall;
    $fell(serial_irq_r) |-> !$past(hreadyout) || !$past(hreadyout, 2);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped alone");
  property p_prio;
    !$stable(serial_priority_r) |-> !$past(hreadyout) || !$past(hreadyout, 2);
  endproperty
  a_prio: assert property (p_prio) else $error("priority moved alone");
  c_wr: cover property (taken);
  c_start: cover property ($fell(txd_r));
  c_irq: cover property ($rose(serial_irq_r));
endmodule // serial_port_props
bind enhanced_serial_port serial_port_props serial_port_props_i (
  .hclk              (hclk),
  .hresetn           (hresetn),
  .ce                (ce),
  .hsel              (hsel),
  .htrans            (htrans),
  .hready            (hready),
  .hrdata            (hrdata),
  .hreadyout         (hreadyout),
  .hresp             (hresp),
  .txd_r             (txd_r),
  .serial_irq_r      (serial_irq_r),
  .serial_priority_r (serial_priority_r)
);

// [tb/remote_uart.sv]
`timescale 1ns/100ps
module remote_uart (
  input  wire logic clk,
  input  wire logic line_in,
  output logic      line_out,
  output logic [9:0] rx_word
);
  int   per = 64;
  logic nine = 1'b1;
  event got;
  int   i;
  initial line_out = 1'b1;
  // Decode each frame mid-bit; data, then ninth or stop, then stop
  always begin
    @(negedge line_in);
    repeat (per / 2) @(posedge clk);
    rx_word[9] = 1'b1;
    for (i = 0; i < 9 + nine; i++) begin
      repeat (per) @(posedge clk);
      rx_word[i] = line_in;
    end
    -> got;
  end
  // Bad stop option lets a test provoke a framing error
  task send(input logic [7:0] v, input logic n9, input logic stp);
    logic [10:0] f;
    int          k;
    f = nine ? {stp, n9, v, 1'b0} : {1'b1, stp, v, 1'b0};
    @(posedge clk);
    for (k = 0; k < 10 + nine; k++) begin
      line_out <= f[k];
      repeat (per) @(posedge clk);
    end
    line_out <= 1'b1;
  endtask
endmodule // remote_uart

// [tb/enhanced_serial_port_bench.sv]
`timescale 1ns/100ps
`include "serial_port_regs.vh"
module enhanced_serial_port_bench;
  logic        hclk;
  logic        hresetn;
  logic        ce;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  [31:0] hrdata;
  wire         hreadyout;
  wire         hresp;
  wire         txd_r;
  wire         rxd_o_r;
  wire         rxd_oe_r;
  wire         serial_irq_r;
  wire  [1:0]  serial_priority_r;
  wire         line_out;
  wire  [9:0]  rx_word;
  logic [32:0] rd_val;
  logic [17:0] q;
  logic [17:0] exp_q[$];
  logic [9:0]  fr_q[$];
  int          mismatches = 0;
  int          cmp_count = 0;
  int          seed = 32'hfca3;
  logic [7:0]  d;
  logic        n;
  logic [7:0]  sh_w;
  int          sh_n = 0;
  logic        clk_q = 1'b1;
  event        rd_ev;
  // Port drives the shared pin only in shift mode
  wire         rxd_i = rxd_oe_r ? rxd_o_r : line_out;
  enhanced_serial_port enhanced_serial_port_i (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .txd_r(txd_r), .rxd_i(rxd_i), .rxd_o_r(rxd_o_r), .rxd_oe_r(rxd_oe_r),
    .serial_irq_r(serial_irq_r), .serial_priority_r(serial_priority_r)
  );
  remote_uart remote_uart_i (
    .clk(hclk), .line_in(txd_r), .line_out(line_out), .rx_word(rx_word)
  );
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  task check(input string what, input logic [32:0] seen, input logic [32:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Single word transfer; the wait bound stands in for a hung slave
  task bus(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int t;
    t = 0;
    hsel   <= 1'b1;
    haddr  <= {22'h0, idx, 2'b00};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 50);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1 && ++t < 50);
    if (t >= 50) mismatches++;
    rd_val = {serial_irq_r, hrdata};
    if (!w) -> rd_ev;
  endtask
  task wr(input logic [7:0] idx, input logic [7:0] v);
    bus(1'b1, idx, {24'h0, v});
  endtask
  // Mask and expectation hold the request line in bit 8
  task rd(input logic [7:0] idx, input logic [8:0] m, input logic [8:0] e);
    exp_q.push_back({m, e});
    bus(1'b0, idx, 32'h0);
  endtask
  task txf(input logic [7:0] c, input int p);
    remote_uart_i.per = p;
    remote_uart_i.nine = c[7];
    wr(`SER_CTRL_IDX, c);
    d = $random(seed);
    fr_q.push_back({1'b1, c[7] ? c[3] : 1'b1, d});
    wr(`SER_BUF_IDX, d);
    repeat (12 * p) @(posedge hclk);
    rd(`SER_CTRL_IDX, 9'h002, 9'h002);
  endtask
  task rxf(input logic [7:0] v, input logic nb, input logic stp);
    remote_uart_i.send(v, nb, stp);
    repeat (8) @(posedge hclk);
  endtask
  // Monitors pair each observed result with the oldest note
  initial forever begin
    @(rd_ev);
    q = exp_q.pop_front();
    check("hrdata", rd_val & {q[17], 24'hFFFFFF, q[16:9]}, {q[8], 24'h0, q[7:0]});
  end
  initial forever begin
    @(remote_uart_i.got);
    check("frame", {23'h0, rx_word}, {23'h0, fr_q.pop_front()});
  end
  // Shift mode data stands at each rising shift clock while driven
  always @(negedge hclk) begin
    if (rxd_oe_r && txd_r && !clk_q) begin
      sh_w = {rxd_o_r, sh_w[7:1]};
      if (++sh_n == 8) check("shift", {25'h0, sh_w}, {23'h0, fr_q.pop_front()});
    end
    clk_q = txd_r;
  end
  task results();
    if (mismatches == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #400000;
    mismatches++;
    results();
  end
  initial begin
    hresetn = 1'b0; ce = 1'b1; hsel = 1'b0; haddr = 32'h0;
    htrans = 2'b00; hwrite = 1'b0; hsize = 3'b010; hwdata = 32'h0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    rd(`SER_CTRL_IDX, 9'h1FF, 9'h000);
    rd(`PWR_RATE_IDX, 9'h0FF, 9'h010);
    d = $random(seed);
    wr(`NODE_MASK_IDX, d);
    rd(`NODE_MASK_IDX, 9'h0FF, {1'b0, d});
    wr(8'h10, 8'hFF);
    rd(8'h10, 9'h0FF, 9'h000);
    wr(`PRIO_HIGH_IDX, 8'h10);
    wr(`INT_EN_IDX, 8'h90);
    check("priority", {31'h0, serial_priority_r}, 33'h2);
    txf(8'h88, 64);
    rd(`SER_CTRL_IDX, 9'h100, 9'h100);
    wr(`SER_CTRL_IDX, 8'h88);
    rd(`SER_CTRL_IDX, 9'h102, 9'h000);
    wr(`PWR_RATE_IDX, 8'h90);
    txf(8'h80, 32);
    txf(8'h40, 16);
    wr(`PWR_RATE_IDX, 8'h10);
    txf(8'hC8, 32);
    // Receive while sending, then overrun the unread character
    n = $random(seed);
    fr_q.push_back({2'b11, 8'h5A});
    wr(`SER_CTRL_IDX, 8'hD8);
    wr(`SER_BUF_IDX, 8'h5A);
    d = $random(seed);
    rxf(d, n, 1'b1);
    rxf(~d, 1'b1, 1'b1);
    rd(`SER_BUF_IDX, 9'h0FF, {1'b0, d});
    rd(`SER_CTRL_IDX, 9'h007, {6'h0, n, 2'b11});
    wr(`SER_CTRL_IDX, 8'hC0);
    rxf(8'hA5, 1'b1, 1'b1);
    rd(`SER_CTRL_IDX, 9'h001, 9'h000);
    wr(`NODE_ADDR_IDX, 8'h12);
    wr(`NODE_MASK_IDX, 8'hFF);
    wr(`SER_CTRL_IDX, 8'hF0);
    rxf(8'h34, 1'b1, 1'b1);
    rxf(8'h12, 1'b0, 1'b1);
    rd(`SER_CTRL_IDX, 9'h001, 9'h000);
    rxf(8'h12, 1'b1, 1'b1);
    rd(`SER_BUF_IDX, 9'h0FF, 9'h012);
    wr(`SER_CTRL_IDX, 8'hF0);
    wr(`NODE_MASK_IDX, 8'hF0);
    rxf(8'hF2, 1'b1, 1'b1);
    rd(`SER_BUF_IDX, 9'h0FF, 9'h0F2);
    // Bad stop in mode 1, then a good frame must not clear the error
    wr(`SER_CTRL_IDX, 8'h50);
    remote_uart_i.nine = 1'b0;
    rxf(8'h3C, 1'b1, 1'b0);
    wr(`PWR_RATE_IDX, 8'h50);
    rd(`SER_CTRL_IDX, 9'h080, 9'h080);
    rxf(8'h3C, 1'b1, 1'b1);
    rd(`SER_CTRL_IDX, 9'h080, 9'h080);
    wr(`SER_CTRL_IDX, 8'h50);
    rd(`SER_CTRL_IDX, 9'h0C0, 9'h040);
    // Mode 1 address filter also wants a good stop bit
    wr(`SER_CTRL_IDX, 8'h70);
    rxf(8'h12, 1'b1, 1'b0);
    rd(`SER_CTRL_IDX, 9'h001, 9'h000);
    rxf(8'h12, 1'b1, 1'b1);
    rd(`SER_BUF_IDX, 9'h0FF, 9'h012);
    // Shift register mode transmit, multiprocessor enable kept clear
    wr(`SER_CTRL_IDX, 8'h00);
    d = $random(seed);
    fr_q.push_back({2'b00, d});
    wr(`SER_BUF_IDX, d);
    repeat (110) @(posedge hclk);
    rd(`SER_CTRL_IDX, 9'h002, 9'h002);
    check("frames left", {1'b0, fr_q.size()}, 33'h0);
    results();
  end
endmodule // enhanced_serial_port_bench
